/* File: common/pcd_regs.vh */
`ifndef PCD_REGS_VH
`define PCD_REGS_VH
`define PCD_OFS_ADDR 8'h00
`define PCD_OFS_COUNT 8'h04
`define PCD_OFS_STAT 8'h08
`define PCD_OFS_MASK 8'h0c
`define PCD_IO_NORM 8'h00
`define PCD_IO_NORM_TC 8'h04
`define PCD_IO_VFY 8'h0c
`define PCD_IO_VFY_TC 8'h04
`define PCD_IO_VFY_BASE 8'hc0
`define PCD_CMD_DIS 2
`define PCD_MODE_DIR 2
`define PCD_MODE_DIR_W 2
`define PCD_STAT_TC 0
`define PCD_STAT_REQ 4
`define PCD_SYS_GEN 3
`define PCD_SYS_CHAN_LO 16
`define PCD_SYS_SLOT 19
`define PCD_DIR_WRITE 2'b01
`define PCD_DIR_READ 2'b10
`define PCD_SER_LEN 4'h8
`define PCD_CHAN_UNUSED 3'h4
`define PCD_PIN_AUDIO 2'b00
`define PCD_PIN_WIDE 2'b01
`define PCD_PIN_INACK 2'b10
`endif

/* File: verilog/pcd_dma.v */
`timescale 1ns/1ps
`include "pcd_regs.vh"
module pcd_dma #(
  parameter AW = 32,
  parameter BUF_DEPTH = 2
) (
  input wire sys_clk_i,
  input wire rstn_i,
  // socket dma control 0 and 1, system control
  input wire distributed_dma_enable_i,
  input wire [1:0] card_dma_request_pin_sel_i,
  input wire [15:0] distributed_dma_base_i,
  input wire distributed_dma_word_i,
  input wire [31:0] sys_ctrl_i,
  input wire sys_ctrl_we_i,
  input wire multifunction_pin_2_route_i,
  input wire multifunction_pin_5_route_i,
  // pci target i/o port
  input wire io_valid_i,
  input wire io_write_i,
  input wire [15:0] io_addr_i,
  input wire [3:0] io_be_i,
  input wire [31:0] io_wdata_i,
  output reg io_ack_o,
  output reg [31:0] io_rdata_o,
  output reg [31:0] sys_ctrl_o,
  // pci master port
  output reg pci_req_o,
  input wire pci_gnt_i,
  input wire pci_idle_i,
  output reg mem_valid_o,
  output reg mem_write_o,
  output reg [AW-1:0] mem_addr_o,
  output reg [15:0] mem_wdata_o,
  input wire mem_done_i,
  input wire [15:0] mem_rdata_i,
  // serial request/grant on multifunction pins
  output reg multifunction_pin_2_o,
  input wire multifunction_pin_5_i,
  // card side
  input wire card_audio_pin_i,
  input wire card_wide_io_pin_i,
  input wire card_input_ack_pin_i,
  input wire card_strobe_i,
  input wire [15:0] card_rdata_i,
  output reg card_dma_acknowledge_n_o,
  output reg card_oe_tc_o,
  output reg card_we_tc_o,
  output reg [15:0] card_wdata_o,
  output reg card_wvalid_o,
  input wire card_wready_i
);
  localparam S_IDLE = 3'd0;
  localparam S_COLLECT = 3'd1;
  localparam S_REQ = 3'd2;
  localparam S_BUS = 3'd3;
  localparam S_DONE = 3'd4;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] base_addr;
  reg [31:0] cur_addr;
  reg [31:0] base_count;
  reg [31:0] cur_count;
  reg [7:0] command;
  reg [7:0] mode;
  reg mask;
  reg tc_flag;
  reg [15:0] hold_data;
  reg card_card_dma_request;
  // buffer between pci read data and card
  reg [15:0] buf_mem [0:BUF_DEPTH-1];
  reg [1:0] buf_cnt;
  reg buf_wp;
  reg buf_rp;
  wire buf_in_ready = (buf_cnt != BUF_DEPTH);
  wire buf_in_valid = (state == S_BUS) && mem_done_i && !mode[`PCD_MODE_DIR];
  wire buf_out_fire = card_wvalid_o && card_wready_i;
  // request pin mux from socket dma control 0
  always @*
  begin
    case (card_dma_request_pin_sel_i)
      `PCD_PIN_AUDIO: card_card_dma_request = card_audio_pin_i;
      `PCD_PIN_WIDE: card_card_dma_request = card_wide_io_pin_i;
      `PCD_PIN_INACK: card_card_dma_request = card_input_ack_pin_i;
      default: card_card_dma_request = 1'b0;
    endcase
  end
  wire central = sys_ctrl_o[`PCD_SYS_GEN] && sys_ctrl_o[`PCD_SYS_SLOT];
  wire [2:0] chan = sys_ctrl_o[`PCD_SYS_CHAN_LO+2:`PCD_SYS_CHAN_LO];
  wire chan_ok = chan != `PCD_CHAN_UNUSED;
  wire distributed_dma_on = distributed_dma_enable_i && !central && !mask && !command[`PCD_CMD_DIS];
  wire io_hit = io_valid_i && (io_addr_i[15:8] == distributed_dma_base_i[15:8]);
  wire [7:0] io_ofs = io_addr_i[7:0];
  wire master_clear = io_hit && io_write_i && io_ofs == `PCD_OFS_MASK && io_be_i[1];
  wire step = (state == S_BUS) && mem_done_i;
  wire last = (cur_count == 32'h0000_0000);
  wire card_to_mem = mode[`PCD_MODE_DIR];
  wire [31:0] stride = distributed_dma_word_i ? 32'h0000_0002 : 32'h0000_0001;
  // serial request shift state, central mode
  reg [3:0] ser_cnt;
  reg [7:0] ser_shift;
  reg granted;
  reg [3:0] gnt_cnt;
  // transfer state machine
  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (distributed_dma_on && card_card_dma_request && !tc_flag)
          next_state = card_to_mem ? S_COLLECT : S_REQ;
      S_COLLECT:
        if (card_strobe_i)
          next_state = S_REQ;
        else if (!card_card_dma_request)
          next_state = S_IDLE;
      S_REQ:
        if (pci_gnt_i && pci_idle_i && (card_to_mem || buf_in_ready))
          next_state = S_BUS;
      S_BUS:
        if (mem_done_i)
          next_state = last ? S_DONE : (card_card_dma_request ? (card_to_mem ? S_COLLECT : S_REQ) : S_IDLE);
      S_DONE:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
    if (master_clear && state != S_IDLE)
      next_state = S_DONE;
  end
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      state <= S_IDLE;
      pci_req_o <= 1'b0;
      mem_valid_o <= 1'b0;
      mem_write_o <= 1'b0;
      mem_addr_o <= {AW{1'b0}};
      mem_wdata_o <= 16'h0000;
      hold_data <= 16'h0000;
      card_dma_acknowledge_n_o <= 1'b1;
      card_oe_tc_o <= 1'b0;
      card_we_tc_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == S_COLLECT && card_strobe_i)
        hold_data <= distributed_dma_word_i ? card_rdata_i : {8'h00, card_rdata_i[7:0]};
      pci_req_o <= (next_state == S_REQ);
      mem_valid_o <= (next_state == S_BUS) && !mem_done_i;
      mem_write_o <= card_to_mem;
      mem_addr_o <= cur_addr[AW-1:0];
      mem_wdata_o <= hold_data;
      // demand mode acknowledge on attribute-select pin
      card_dma_acknowledge_n_o <= !(next_state != S_IDLE && next_state != S_DONE);
      // tc on oe for card-to-memory, we for memory-to-card
      card_oe_tc_o <= (next_state == S_DONE) && card_to_mem;
      card_we_tc_o <= (next_state == S_DONE) && !card_to_mem;
    end
  end
  // two-entry buffer; card stall back-pressures the bus request
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      buf_cnt <= 2'd0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      card_wvalid_o <= 1'b0;
      card_wdata_o <= 16'h0000;
    end
    else
    begin
      if (buf_in_valid && buf_in_ready)
      begin
        buf_mem[buf_wp] <= distributed_dma_word_i ? mem_rdata_i : {8'h00, mem_rdata_i[7:0]};
        buf_wp <= ~buf_wp;
      end
      if ((!card_wvalid_o || buf_out_fire) && buf_cnt != 2'd0 && !(buf_out_fire && buf_cnt == 2'd1))
      begin
        card_wvalid_o <= 1'b1;
        card_wdata_o <= buf_mem[buf_rp];
        buf_rp <= ~buf_rp;
      end
      else if (buf_out_fire)
        card_wvalid_o <= 1'b0;
      buf_cnt <= buf_cnt + {1'b0, buf_in_valid && buf_in_ready}
        - {1'b0, (!card_wvalid_o || buf_out_fire) && buf_cnt != 2'd0
        && !(buf_out_fire && buf_cnt == 2'd1)};
    end
  end
  // distributed register writes; target stays live during transfers
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      base_addr <= 32'h0000_0000;
      cur_addr <= 32'h0000_0000;
      base_count <= 32'h0000_0000;
      cur_count <= 32'h0000_0000;
      command <= 8'h00;
      mode <= 8'h00;
      mask <= 1'b1;
      tc_flag <= 1'b0;
    end
    else
    begin
      if (step)
      begin
        cur_addr <= cur_addr + stride;
        cur_count <= cur_count - 32'h0000_0001;
      end
      if (io_hit && io_write_i && !central)
      begin
        case (io_ofs)
          `PCD_OFS_ADDR:
          begin
            // top byte is reserved: reads zero, writes ignored
            base_addr <= {8'h00, io_wdata_i[23:0]};
            cur_addr <= {8'h00, io_wdata_i[23:0]};
          end
          `PCD_OFS_COUNT:
          begin
            base_count <= {8'h00, io_wdata_i[23:0]};
            cur_count <= {8'h00, io_wdata_i[23:0]};
          end
          `PCD_OFS_STAT:
          begin
            if (io_be_i[0])
              command <= io_wdata_i[7:0];
            if (io_be_i[3])
              mode <= io_wdata_i[31:24];
          end
          `PCD_OFS_MASK:
          begin
            if (io_be_i[3])
              mask <= io_wdata_i[24];
          end
          default:
            mask <= mask;
        endcase
      end
      if (master_clear)
        mask <= 1'b1;
      // set wins over the read-to-clear
      if (next_state == S_DONE)
        tc_flag <= 1'b1;
      else if (io_hit && !io_write_i && io_ofs == `PCD_OFS_STAT)
        tc_flag <= 1'b0;
      else if (io_hit && io_write_i && io_ofs == `PCD_OFS_ADDR)
        tc_flag <= 1'b0;
    end
  end
  // target reads and central i/o cycles
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      io_ack_o <= 1'b0;
      io_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      io_ack_o <= io_hit || (central && granted && io_valid_i);
      io_rdata_o <= 32'h0000_0000;
      if (central && granted && io_valid_i)
      begin
        if (io_ofs == `PCD_IO_NORM || io_ofs == `PCD_IO_NORM_TC)
          io_rdata_o <= {16'h0000, card_rdata_i};
        else if (!io_write_i && (io_ofs == `PCD_IO_VFY_BASE
          || io_ofs == (`PCD_IO_VFY_BASE | `PCD_IO_VFY_TC)))
          io_rdata_o <= 32'h0000_0000;
      end
      else if (io_hit && !io_write_i)
      begin
        case (io_ofs)
          `PCD_OFS_ADDR: io_rdata_o <= {8'h00, cur_addr[23:0]};
          `PCD_OFS_COUNT: io_rdata_o <= {8'h00, cur_count[23:0]};
          `PCD_OFS_STAT: io_rdata_o <= {24'h00_0000, 3'b000, card_card_dma_request, 3'b000, tc_flag};
          `PCD_OFS_MASK: io_rdata_o <= {7'h00, mask, 24'h00_0000};
          default: io_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // system control and central serial request/grant
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      sys_ctrl_o <= 32'h0000_0008;
      ser_cnt <= 4'h0;
      ser_shift <= 8'h00;
      granted <= 1'b0;
      gnt_cnt <= 4'h0;
      multifunction_pin_2_o <= 1'b1;
    end
    else
    begin
      if (sys_ctrl_we_i)
        sys_ctrl_o <= sys_ctrl_i;
      // start bit then one-cold channel frame (only the channel bit low), serialized
      if (ser_cnt != 4'h0)
      begin
        multifunction_pin_2_o <= !multifunction_pin_2_route_i || ser_shift[0];
        ser_shift <= {1'b1, ser_shift[7:1]};
        ser_cnt <= ser_cnt - 4'h1;
      end
      else if (central && chan_ok && card_card_dma_request && !granted && multifunction_pin_2_route_i)
      begin
        multifunction_pin_2_o <= 1'b0;
        ser_shift <= ~(8'h01 << chan);
        ser_cnt <= `PCD_SER_LEN;
      end
      else
        multifunction_pin_2_o <= 1'b1;
      // grant frame: low start bit then channel bits
      if (multifunction_pin_5_route_i && central && !multifunction_pin_5_i && gnt_cnt == 4'h0)
        gnt_cnt <= `PCD_SER_LEN;
      else if (gnt_cnt != 4'h0)
      begin
        gnt_cnt <= gnt_cnt - 4'h1;
        if ({1'b0, chan} == 4'h8 - gnt_cnt && !multifunction_pin_5_i)
          granted <= 1'b1;
      end
      if (!card_card_dma_request || !central || (io_valid_i && io_ofs[2]))
        granted <= 1'b0;
    end
  end
endmodule

/* File: tb/pcd_dma_monitor.sv */
`timescale 1ns/1ps
module pcd_dma_monitor (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire io_valid_i,
  input wire io_ack_o,
  input wire [31:0] sys_ctrl_o,
  input wire pci_req_o,
  input wire pci_gnt_i,
  input wire pci_idle_i,
  input wire mem_valid_o,
  input wire mem_done_i,
  input wire [31:0] mem_addr_o,
  input wire card_dma_acknowledge_n_o,
  input wire card_oe_tc_o,
  input wire card_we_tc_o,
  input wire [15:0] card_wdata_o,
  input wire card_wvalid_o,
  input wire card_wready_i
);
  // one clock domain, so one default for all checks
  default clocking mcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire term_cnt = card_oe_tc_o || card_we_tc_o;
  reset_ctrl_a: assert property ($rose(rstn_i) |-> sys_ctrl_o[3] && !sys_ctrl_o[19])
    else $error("system control reset value wrong");
  req_hold_a: assert property (pci_req_o && !(pci_gnt_i && pci_idle_i) |=> pci_req_o)
    else $error("bus request dropped before grant");
  phase_hold_a: assert property (mem_valid_o && !mem_done_i |=> mem_valid_o && $stable(mem_addr_o))
    else $error("data phase not held");
  ack_held_a: assert property (mem_valid_o |-> !card_dma_acknowledge_n_o)
    else $error("card acknowledge off during phase");
  io_answer_a: assert property (io_ack_o |-> $past(io_valid_i))
    else $error("io answer without request");
  strobe_split_a: assert property (!(card_oe_tc_o && card_we_tc_o))
    else $error("both end strobes at once");
  count_pulse_a: assert property (term_cnt |=> !term_cnt)
    else $error("end pulse too long");
  ack_release_a: assert property (term_cnt |-> ##[0:1] card_dma_acknowledge_n_o)
    else $error("card acknowledge kept after end");
  req_stop_a: assert property (term_cnt |=> !pci_req_o [*2])
    else $error("bus request after end");
  stream_hold_a: assert property (card_wvalid_o && !card_wready_i |=> card_wvalid_o && $stable(card_wdata_o))
    else $error("card stream word lost");
  c_phase: cover property (mem_valid_o && mem_done_i);
  c_oe: cover property (card_oe_tc_o);
  c_we: cover property (card_we_tc_o);
endmodule
bind pcd_dma pcd_dma_monitor mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .io_valid_i(io_valid_i),
  .io_ack_o(io_ack_o), .sys_ctrl_o(sys_ctrl_o), .pci_req_o(pci_req_o), .pci_gnt_i(pci_gnt_i),
  .pci_idle_i(pci_idle_i), .mem_valid_o(mem_valid_o), .mem_done_i(mem_done_i),
  .mem_addr_o(mem_addr_o), .card_dma_acknowledge_n_o(card_dma_acknowledge_n_o),
  .card_oe_tc_o(card_oe_tc_o), .card_we_tc_o(card_we_tc_o), .card_wdata_o(card_wdata_o),
  .card_wvalid_o(card_wvalid_o), .card_wready_i(card_wready_i));

/* File: tb/pcd_pci_model.sv */
`timescale 1ns/1ps
module pcd_pci_model (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire req_i,
  input wire valid_i,
  input wire [31:0] addr_i,
  output reg gnt_o,
  output reg idle_o,
  output reg done_o,
  output reg [15:0] rdata_o
);
  reg [1:0] wait_cnt;
  reg slow;
  // grant an idle bus; phases end promptly and slowly in turn
  always @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      gnt_o <= 1'b0;
      idle_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      wait_cnt <= 2'b00;
      slow <= 1'b0;
    end
    else
    begin
      gnt_o <= req_i;
      idle_o <= 1'b1;
      done_o <= 1'b0;
      rdata_o <= ~rdata_o; // stale data never holds still
      if (valid_i && !done_o)
      begin
        wait_cnt <= wait_cnt + 2'b01;
        if (wait_cnt == {slow, slow})
        begin
          done_o <= 1'b1;
          rdata_o <= addr_i[15:0] ^ 16'ha5c3;
          wait_cnt <= 2'b00;
          slow <= ~slow;
        end
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg sys_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg distributed_dma_enable_i = 1'b0;
  reg [1:0] card_dma_request_pin_sel_i = 2'b00;
  reg distributed_dma_word_i = 1'b0;
  reg [31:0] sys_ctrl_i = 32'h0000_0000;
  reg sys_ctrl_we_i = 1'b0;
  reg io_valid_i = 1'b0;
  reg io_write_i = 1'b0;
  reg [15:0] io_addr_i = 16'h0000;
  reg [3:0] io_be_i = 4'h0;
  reg [31:0] io_wdata_i = 32'h0000_0000;
  reg card_audio_pin_i = 1'b0;
  reg card_wide_io_pin_i = 1'b0;
  reg card_input_ack_pin_i = 1'b0;
  reg card_strobe_i = 1'b0;
  reg [15:0] card_rdata_i = 16'h0000;
  reg card_wready_i = 1'b0;
  wire io_ack_o, pci_req_o, pci_gnt_i, pci_idle_i, mem_valid_o, mem_write_o, mem_done_i;
  wire card_dma_acknowledge_n_o, card_oe_tc_o, card_we_tc_o, card_wvalid_o;
  wire [31:0] io_rdata_o, sys_ctrl_o, mem_addr_o;
  wire [15:0] mem_wdata_o, mem_rdata_i, card_wdata_o;
  integer fails = 0;
  integer samples_checked = 0;
  integer t, k, n;
  reg [15:0] lfsr = 16'hf74d;
  reg [31:0] mq[$], cq[$], iq[$];
  reg [31:0] io_mask = 32'h0000_0000;
  reg io_rd = 1'b0;
  reg to_card = 1'b0;
  reg [15:0] a, d;
  reg [7:0] n_oe = 8'h00, n_we = 8'h00, o0, w0;
  pcd_dma dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .distributed_dma_enable_i(distributed_dma_enable_i),
    .card_dma_request_pin_sel_i(card_dma_request_pin_sel_i), .distributed_dma_base_i(16'h0100), .distributed_dma_word_i(distributed_dma_word_i),
    .sys_ctrl_i(sys_ctrl_i), .sys_ctrl_we_i(sys_ctrl_we_i), .multifunction_pin_2_route_i(1'b0),
    .multifunction_pin_5_route_i(1'b0), .io_valid_i(io_valid_i), .io_write_i(io_write_i),
    .io_addr_i(io_addr_i), .io_be_i(io_be_i), .io_wdata_i(io_wdata_i), .io_ack_o(io_ack_o),
    .io_rdata_o(io_rdata_o), .sys_ctrl_o(sys_ctrl_o), .pci_req_o(pci_req_o),
    .pci_gnt_i(pci_gnt_i), .pci_idle_i(pci_idle_i), .mem_valid_o(mem_valid_o),
    .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_done_i(mem_done_i), .mem_rdata_i(mem_rdata_i), .multifunction_pin_2_o(),
    .multifunction_pin_5_i(1'b1), .card_audio_pin_i(card_audio_pin_i),
    .card_wide_io_pin_i(card_wide_io_pin_i), .card_input_ack_pin_i(card_input_ack_pin_i),
    .card_strobe_i(card_strobe_i), .card_rdata_i(card_rdata_i),
    .card_dma_acknowledge_n_o(card_dma_acknowledge_n_o), .card_oe_tc_o(card_oe_tc_o),
    .card_we_tc_o(card_we_tc_o), .card_wdata_o(card_wdata_o), .card_wvalid_o(card_wvalid_o),
    .card_wready_i(card_wready_i));
  pcd_pci_model host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(pci_req_o),
    .valid_i(mem_valid_o), .addr_i(mem_addr_o), .gnt_o(pci_gnt_i), .idle_o(pci_idle_i),
    .done_o(mem_done_i), .rdata_o(mem_rdata_i));
  always #2.5 sys_clk_i = ~sys_clk_i;
  function [15:0] nxt(input [15:0] s);
    nxt = s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction
  task cmp(input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (e !== g)
      begin
        fails = fails + 1;
        $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // a bound that runs out ends the run as a failure
  task lim(input integer c);
    if (c >= 400)
    begin
      fails = fails + 1;
      stop_test;
    end
  endtask
  task io(input w, input [7:0] ofs, input [31:0] v, input [31:0] m);
    begin
      @(posedge sys_clk_i);
      io_rd <= !w;
      io_mask <= m;
      if (!w)
        iq.push_back(v & m);
      io_valid_i <= 1'b1;
      io_write_i <= w;
      io_addr_i <= {8'h01, ofs};
      // mask lives in byte 3; byte 1 at 0Ch would master-clear
      io_be_i <= (ofs == 8'h0c) ? 4'h8 : 4'hf;
      io_wdata_i <= v;
      @(posedge sys_clk_i);
      io_valid_i <= 1'b0;
      t = 0;
      while (io_ack_o !== 1'b1 && t < 400)
      begin
        @(posedge sys_clk_i);
        t = t + 1;
      end
      lim(t);
    end
  endtask
  // program 3 transfers, feed or take card data, then expect one end pulse
  task run(input c2m, input [1:0] pin, input w);
    begin
      distributed_dma_word_i <= w;
      card_dma_request_pin_sel_i <= pin;
      distributed_dma_enable_i <= 1'b1;
      to_card <= !c2m;
      io(1'b1, 8'h00, 32'h0000_1000, 32'h0);
      io(1'b1, 8'h04, 32'h0000_0002, 32'h0);
      io(1'b1, 8'h08, {5'h00, c2m, 26'h0}, 32'h0);
      io(1'b1, 8'h0c, 32'h0000_0000, 32'h0);
      o0 = n_oe;
      w0 = n_we;
      {card_input_ack_pin_i, card_wide_io_pin_i, card_audio_pin_i} <= 3'b001 << pin;
      for (n = 0; n < 3; n = n + 1)
      begin
        a = 16'h1000 + (w ? 2 * n : n);
        d = w ? lfsr : {8'h00, lfsr[7:0]};
        mq.push_back({a[14:0], c2m, c2m ? d : 16'h0000});
        if (!c2m)
          cq.push_back(w ? a ^ 16'ha5c3 : {8'h00, a[7:0] ^ 8'hc3});
        card_rdata_i <= lfsr;
        card_strobe_i <= c2m;
        // strobe stays up until the phase ends so the collect state always sees it
        t = 0;
        @(posedge sys_clk_i);
        while (!(mem_valid_o === 1'b1 && mem_done_i === 1'b1) && t < 400)
        begin
          @(posedge sys_clk_i);
          t = t + 1;
        end
        lim(t);
      end
      card_strobe_i <= 1'b0;
      t = 0;
      while ((n_oe == o0 && n_we == w0 || cq.size() != 0) && t < 400)
      begin
        @(posedge sys_clk_i);
        t = t + 1;
      end
      lim(t);
      cmp({7'h00, c2m, 7'h00, !c2m}, {n_oe - o0, n_we - w0});
      {card_input_ack_pin_i, card_wide_io_pin_i, card_audio_pin_i} <= 3'b000;
      io(1'b0, 8'h08, 32'h0000_0001, 32'h0000_0001);
      $display("test transfer dir %0d pin %0d word %0d done", c2m, pin, w);
    end
  endtask
  // random card data and receiver stalls
  always @(posedge sys_clk_i)
  begin
    lfsr <= nxt(lfsr);
    card_wready_i <= lfsr[0];
  end
  // take the oldest note whenever a result shows
  always @(posedge sys_clk_i)
  begin
    if (card_oe_tc_o === 1'b1)
      n_oe <= n_oe + 8'h01;
    if (card_we_tc_o === 1'b1)
      n_we <= n_we + 8'h01;
    if (io_ack_o === 1'b1 && io_rd && iq.size() > 0)
      cmp(iq.pop_front(), io_rdata_o & io_mask);
    if (mem_valid_o === 1'b1 && mem_done_i === 1'b1 && mq.size() > 0)
      cmp(mq.pop_front(), {mem_addr_o[14:0], mem_write_o, to_card ? 16'h0000
        : (distributed_dma_word_i ? mem_wdata_o : {8'h00, mem_wdata_o[7:0]})});
    if (card_wvalid_o === 1'b1 && card_wready_i === 1'b1 && cq.size() > 0)
      cmp(cq.pop_front(), distributed_dma_word_i ? card_wdata_o : {8'h00, card_wdata_o[7:0]});
  end
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    cmp(32'h0000_0008, sys_ctrl_o);
    io(1'b1, 8'h00, 32'hff12_3456, 32'h0);
    io(1'b0, 8'h00, 32'h0012_3456, 32'hffff_ffff);
    io(1'b1, 8'h04, 32'hffff_ffff, 32'h0);
    io(1'b0, 8'h04, 32'h00ff_ffff, 32'hffff_ffff);
    io(1'b1, 8'h10, 32'hffff_ffff, 32'h0);
    io(1'b0, 8'h10, 32'h0000_0000, 32'hffff_ffff);
    $display("test registers done");
    for (k = 0; k < 6; k = k + 1)
      run(k < 3, k % 3, k[0]);
    stop_test;
  end
endmodule
